// ===== src/smcg_top.sv
// Stop-mode clock gating and synthesizer status, reached over AHB-Lite.
// Assumes one AHB-Lite master, status straps stable at reset release,
// and raw lock/loss inputs from the analog PLL domain.
//
// Function
// [R1] Fast wakeup set: system clocks restart at wakeup without waiting for lock.
// [R2] Fast wakeup clear: system clocks stay gated at wakeup until PLL locks.
// [R3] Fast wakeup clear with clock lost in stop: wake self-clocked or reference mode.
// [R4] External clock mode ignores the fast wakeup bit during wakeup.
// [R5] Stop mode 00 gates system clocks only; 01 also gates clock output.
// [R6] Stop mode 10 keeps only oscillator; 11 turns everything off.
// [R7] Software writes zero to reserved control bits 4 and 1-0.
// [R8] Status register is read-only and readable at any time.
// [R9] Status writes change nothing and end with an OKAY response.
// [R10] Status initial contents come from reset configuration straps.
// [R11] Lock reported within about 0.75 percent, lost beyond about 1.5 percent.
// [R12] Stop mode fields act only on stop entry and exit.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "smcg_cfg.svh"
module smcg_top
  import smcg_pkg::*;
#(
  parameter logic [15:0] LOCK_WIN = `SMCG_CMP_WIN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic strap_pll_mode,
  input wire logic strap_pll_sel,
  input wire logic strap_pll_ref,
  input wire logic stop_req,
  input wire logic wake_req,
  input wire logic pll_tick,
  input wire logic osc_lost,
  input wire logic [15:0] lock_expected,
  output logic sys_clk_en,
  output logic pll_en,
  output logic osc_en,
  output logic clock_output_pin_en,
  output logic self_clocked,
  output logic ref_clock_mode
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic pll_tick_prev_q;
  logic tick_pulse;

  // Pins from outside pass two flops; the first is read only by the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      pll_tick_prev_q <= 1'b0;
    end else begin
      sync1_q <= {pll_tick, osc_lost, wake_req, stop_req};
      sync2_q <= sync1_q;
      pll_tick_prev_q <= sync2_q[3];
    end
  end
  assign tick_pulse = sync2_q[3] & ~pll_tick_prev_q;

  logic pll_locked;
  smcg_lock_det #(.WIN(LOCK_WIN)) u_lock (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pll_tick(tick_pulse),
    .expected(lock_expected),
    .locked(pll_locked)
  );

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic [15:0] ctrl_q;
  logic [7:0] stat_q;
  logic wr_pend_q;
  logic [11:0] addr_q;
  logic [31:0] rdata_d;
  logic ahb_take;
  logic straps_taken_q;
  smcg_state_t state_q;

  assign ahb_take = hsel & hready & htrans[1];

  // Address phase capture; every access answers in its first data cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= ahb_take & hwrite;
      addr_q <= ahb_take ? haddr : addr_q;
    end
  end

  // Control write; reserved bits are masked so stray ones cannot stick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= `SMCG_CTRL_RST;
    end else if (wr_pend_q && addr_q == `SMCG_CTRL_OFS) begin
      ctrl_q <= hwdata[15:0] & `SMCG_CTRL_WMASK; // R7
    end
  end
  // A status write falls through here untouched and still ends OKAY. R9

  // Read mux, decoded at the address phase so data meets the next edge
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr)
      `SMCG_CTRL_OFS: rdata_d = {16'h0000, ctrl_q};
      `SMCG_STAT_OFS: rdata_d = {24'h00_0000, stat_q}; // R8
      `SMCG_STOP_OFS: rdata_d = {30'h0, state_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (ahb_take && !hwrite) ? rdata_d : 32'h0000_0000;
      hreadyout <= 1'b1; // Zero wait states
      hresp <= 1'b0; // R9
    end
  end

  // ************************************************************
  // Status register
  // ************************************************************
  logic locks_q;
  logic stopped_pll_q;

  // Straps caught on the first clock after reset release, never in reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      straps_taken_q <= 1'b0;
      stat_q <= 8'h00;
    end else begin
      straps_taken_q <= 1'b1;
      if (!straps_taken_q) begin
        stat_q[`SMCG_ST_MODE_BIT] <= strap_pll_mode; // R10
        stat_q[`SMCG_ST_SEL_BIT] <= strap_pll_sel; // R10
        stat_q[`SMCG_ST_REF_BIT] <= strap_pll_ref; // R10
      end
      stat_q[`SMCG_ST_LOCKS_BIT] <= locks_q;
      stat_q[`SMCG_ST_LOCK_BIT] <= stat_q[`SMCG_ST_MODE_BIT] & pll_locked;
      stat_q[`SMCG_ST_LOCA_BIT] <= self_clocked;
      stat_q[`SMCG_ST_LOSS_BIT] <= ref_clock_mode;
      stat_q[0] <= 1'b0;
    end
  end

  // Sticky lock: set on first lock after reset, cleared on loss
  logic lock_seen_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      locks_q <= 1'b0;
      lock_seen_q <= 1'b0;
    end else if (!stat_q[`SMCG_ST_MODE_BIT] || !straps_taken_q) begin
      locks_q <= 1'b0;
    end else if (stopped_pll_q) begin
      locks_q <= locks_q; // Intentionally disabled PLL keeps the old value
    end else if (pll_locked && !lock_seen_q) begin
      locks_q <= 1'b1;
      lock_seen_q <= 1'b1;
    end else if (!pll_locked && lock_seen_q) begin
      locks_q <= 1'b0;
    end
  end

  // ************************************************************
  // Stop and wakeup sequencing
  // ************************************************************
  smcg_smd_t smd_q;
  logic fwk;
  logic ext_mode;

  assign fwk = ctrl_q[`SMCG_FWK_BIT];
  assign ext_mode = ~stat_q[`SMCG_ST_MODE_BIT];

  // Mode is latched on entry so a write during stop cannot disturb it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= SMCG_RUN;
      smd_q <= SMCG_SMD_KEEP_ALL;
    end else begin
      case (state_q)
        SMCG_RUN: if (sync2_q[0]) begin
          state_q <= SMCG_STOP;
          smd_q <= smcg_smd_t'(ctrl_q[`SMCG_SMD_HI:`SMCG_SMD_LO]); // R12
        end
        SMCG_STOP: if (sync2_q[1]) begin
          state_q <= SMCG_WAKE;
        end
        SMCG_WAKE: begin
          // External clock mode walks straight through, whatever fwk says
          if (ext_mode || fwk || pll_locked || self_clocked || ref_clock_mode) begin
            state_q <= SMCG_RUN; // R1 R2 R4
          end
        end
        default: state_q <= SMCG_RUN;
      endcase
    end
  end

  // Resource enables; all on in run, and all but sys_clk_en on in wake
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sys_clk_en <= 1'b1;
      pll_en <= 1'b1;
      osc_en <= 1'b1;
      clock_output_pin_en <= 1'b1;
      stopped_pll_q <= 1'b0;
    end else begin
      case (state_q)
        SMCG_STOP: begin
          sys_clk_en <= 1'b0; // R5 R6
          pll_en <= (smd_q == SMCG_SMD_KEEP_ALL) || (smd_q == SMCG_SMD_NO_CLOCK_OUTPUT_PIN); // R5 R6
          osc_en <= (smd_q != SMCG_SMD_ALL_OFF); // R6
          clock_output_pin_en <= (smd_q == SMCG_SMD_KEEP_ALL); // R5
          stopped_pll_q <= smd_q[1];
        end
        SMCG_WAKE: begin
          pll_en <= 1'b1;
          osc_en <= 1'b1;
          clock_output_pin_en <= 1'b1;
          sys_clk_en <= ext_mode || fwk || pll_locked || self_clocked
            || ref_clock_mode; // R1 R2 R4
        end
        default: begin
          sys_clk_en <= 1'b1; // R12
          pll_en <= 1'b1;
          osc_en <= 1'b1;
          clock_output_pin_en <= 1'b1;
          stopped_pll_q <= 1'b0;
        end
      endcase
    end
  end

  // Unintended clock loss in stop, fast wakeup clear: pick a fallback
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      self_clocked <= 1'b0;
      ref_clock_mode <= 1'b0;
    end else if (state_q == SMCG_STOP && !fwk && !ext_mode) begin
      if (sync2_q[2] && osc_en) begin
        self_clocked <= 1'b1; // R3
      end else if (pll_en && !smd_q[1] && !pll_locked && lock_seen_q) begin
        ref_clock_mode <= 1'b1; // R3
      end
    end else if (state_q == SMCG_RUN && pll_locked && !sync2_q[2]) begin
      self_clocked <= 1'b0;
      ref_clock_mode <= 1'b0;
    end
  end
endmodule

// ===== src/smcg_cfg.svh
// Constants for the stop-mode clock gating block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SMCG_CFG_SVH
`define SMCG_CFG_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SMCG_CTRL_OFS 12'h000
`define SMCG_STAT_OFS 12'h004
`define SMCG_STOP_OFS 12'h008

// ************************************************************
// Control register fields
// ************************************************************
`define SMCG_FWK_BIT 5
`define SMCG_SMD_HI 3
`define SMCG_SMD_LO 2
`define SMCG_CTRL_WMASK 16'hffec
`define SMCG_CTRL_RST 16'h0000

// ************************************************************
// Status register fields
// ************************************************************
`define SMCG_ST_MODE_BIT 7
`define SMCG_ST_SEL_BIT 6
`define SMCG_ST_REF_BIT 5
`define SMCG_ST_LOCKS_BIT 4
`define SMCG_ST_LOCK_BIT 3
`define SMCG_ST_LOCA_BIT 2
`define SMCG_ST_LOSS_BIT 1

// ************************************************************
// Lock detection: thresholds in tenths of a percent deviation, window in reference cycles
// ************************************************************
`define SMCG_LOCK_IN_PERMIL 7.5
`define SMCG_LOCK_OUT_PERMIL 15
`define SMCG_CMP_WIN 16'd1000

`endif

// ===== src/smcg_pkg.sv
// Types shared by the stop-mode clock gating block.
// Assumes the constants header is on the include path.
package smcg_pkg;
  `include "smcg_cfg.svh"

  // Stop-mode resource selection
  typedef enum logic [1:0] {
    SMCG_SMD_KEEP_ALL = 2'b00,
    SMCG_SMD_NO_CLOCK_OUTPUT_PIN = 2'b01,
    SMCG_SMD_OSC_ONLY = 2'b10,
    SMCG_SMD_ALL_OFF = 2'b11
  } smcg_smd_t;

  // Power sequencing states, Gray along run, stop, wake; wake to run flips both bits
  typedef enum logic [1:0] {
    SMCG_RUN = 2'b00,
    SMCG_STOP = 2'b01,
    SMCG_WAKE = 2'b11
  } smcg_state_t;
endpackage

// ===== src/smcg_lock_det.sv
// Lock detector: compares reference-window counts of the synthesized clock.
// Assumes pll_tick is already synchronised to ref_clk as a one-cycle pulse.
`timescale 1ns/1ps
`include "smcg_cfg.svh"
module smcg_lock_det
  import smcg_pkg::*;
#(
  parameter logic [15:0] WIN = `SMCG_CMP_WIN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pll_tick,
  input wire logic [15:0] expected,
  output logic locked
);
  logic [15:0] win_q;
  logic [15:0] cnt_q;

  // Absolute difference between measured and programmed counts
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  // Window timer and tick counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      win_q <= 16'h0000;
      cnt_q <= 16'h0000;
    end else if (win_q == 16'(WIN - 16'h0001)) begin
      win_q <= 16'h0000;
      cnt_q <= {15'h0, pll_tick}; // The wrap cycle's tick opens the next window, none is lost
    end else begin
      win_q <= 16'(win_q + 16'h0001);
      cnt_q <= 16'(cnt_q + {15'h0, pll_tick});
    end
  end

  // Hysteresis: lock within 0.75 %, lose beyond 1.5 %; 0.75 % of n is 3n/400
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else if (win_q == 16'(WIN - 16'h0001)) begin
      if (32'(absdiff(cnt_q, expected)) * 32'd400 <= 32'(expected) * 32'd3) begin
        locked <= 1'b1; // R11
      end else if (32'(absdiff(cnt_q, expected)) * 32'd200 > 32'(expected) * 32'd3) begin
        locked <= 1'b0; // R11
      end
    end
  end
endmodule

// ===== tb/smcg_top_monitor.sv
// Concurrent checks on the stop-mode clock gating top.
// Assumes it is bound to smcg_top and sees only its ports.
`timescale 1ns/1ps
module smcg_top_monitor
  import smcg_pkg::*;
#(
  parameter logic [15:0] LOCK_WIN = 16'd1000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic strap_pll_mode,
  input wire logic strap_pll_sel,
  input wire logic strap_pll_ref,
  input wire logic stop_req,
  input wire logic wake_req,
  input wire logic sys_clk_en,
  input wire logic pll_en,
  input wire logic osc_en,
  input wire logic clock_output_pin_en,
  input wire logic self_clocked,
  input wire logic ref_clock_mode
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic rd_take;
  // Read taken this edge
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  no_wait_a: assert property (hreadyout == 1'b1) else $error("wait state seen");
  rst_on_a: assert property ($rose(rst_n) |-> sys_clk_en && pll_en && osc_en
    && clock_output_pin_en) else $error("enables low after reset");
  idle_data_a: assert property (!rd_take |=> hrdata == 32'h0)
    else $error("hrdata not idle");
  stat_strap_a: assert property (rd_take && haddr == 12'h004 |=>
    hrdata[7:5] == {strap_pll_mode, strap_pll_sel, strap_pll_ref}
    && hrdata[0] == 1'b0) else $error("status straps wrong");
  stop_gate_a: assert property ($rose(stop_req) && !wake_req |-> ##[2:6] !sys_clk_en)
    else $error("system clock not gated");
  pll_out_a: assert property (!pll_en |-> !clock_output_pin_en)
    else $error("clock output without pll");
  osc_pll_a: assert property (!osc_en |-> !pll_en && !sys_clk_en)
    else $error("pll without oscillator");
  // Main scenarios reached
  cover property (!osc_en);
  cover property (rd_take && haddr == 12'h004);
  cover property (self_clocked || ref_clock_mode);
endmodule
bind smcg_top smcg_top_monitor #(.LOCK_WIN(LOCK_WIN)) u_mon (.ref_clk(ref_clk),
  .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .strap_pll_mode(strap_pll_mode), .strap_pll_sel(strap_pll_sel),
  .strap_pll_ref(strap_pll_ref), .stop_req(stop_req), .wake_req(wake_req),
  .sys_clk_en(sys_clk_en), .pll_en(pll_en), .osc_en(osc_en),
  .clock_output_pin_en(clock_output_pin_en), .self_clocked(self_clocked),
  .ref_clock_mode(ref_clock_mode));

// ===== tb/smcg_top_tb_top.sv
// Self-checking bench for the stop-mode clock gating top.
// Assumes a single AHB-Lite master and ticks scaled to a short lock window.
`timescale 1ns/1ps
module smcg_top_tb_top;
  import smcg_pkg::*;
  logic ref_clk = 0, rst_n = 0, hsel = 1, hwrite = 0, rd_ph = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, v;
  logic hreadyout, hresp, hready, sys_clk_en, pll_en, osc_en, clock_output_pin_en;
  logic strap_pll_mode = 1, strap_pll_sel = 0, strap_pll_ref = 0;
  logic stop_req = 0, wake_req = 0, pll_tick = 0, osc_lost = 0, tick_on = 0;
  logic self_clocked, ref_clock_mode;
  logic [15:0] lock_expected = 16'd50;
  logic [3:0] en;
  logic [63:0] q[$];
  int n_fail = 0, total_checks = 0, m;
  assign hready = hreadyout;
  assign en = {sys_clk_en, pll_en, osc_en, clock_output_pin_en};
  smcg_top #(.LOCK_WIN(16'd100)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .strap_pll_mode(strap_pll_mode), .strap_pll_sel(strap_pll_sel),
    .strap_pll_ref(strap_pll_ref), .stop_req(stop_req), .wake_req(wake_req),
    .pll_tick(pll_tick), .osc_lost(osc_lost), .lock_expected(lock_expected),
    .sys_clk_en(sys_clk_en), .pll_en(pll_en), .osc_en(osc_en),
    .clock_output_pin_en(clock_output_pin_en), .self_clocked(self_clocked),
    .ref_clock_mode(ref_clock_mode));
  // ****************************************
  // Clock, ticks and checking
  // ****************************************
  always #2.5 ref_clk = ~ref_clk;
  // Half-rate ticks give 50 rises per 100-cycle window
  always @(posedge ref_clk) pll_tick <= tick_on ? ~pll_tick : 1'b0;
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Oldest note is compared when read data stands
  always @(posedge ref_clk) begin
    if (rd_ph && hreadyout) begin
      chk(hrdata & q[0][31:0], q[0][63:32]);
      void'(q.pop_front());
    end
  end
  task conclude();
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard at 40000 cycles, far beyond the roughly one thousand cycles needed
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  // ****************************************
  // Tasks
  // ****************************************
  // Single AHB-Lite transfer; a read notes expected data and mask
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d, e, k);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    if (!w) q.push_back({e, k});
    rd_ph <= !w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd_ph <= 0;
  endtask
  task reset(input logic mode);
    rst_n <= 0;
    strap_pll_mode <= mode;
    strap_pll_sel <= $urandom;
    strap_pll_ref <= $urandom;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    repeat (3) @(posedge ref_clk);
  endtask
  // Program control, enter stop, check the enables, request wake
  task stop(input logic [15:0] c, input logic [3:0] e);
    bus(12'h000, 1, {16'h0, c}, 0, 0);
    repeat (4) @(posedge ref_clk);
    chk(en, 4'hf);
    stop_req <= 1;
    repeat (10) @(posedge ref_clk);
    chk(en, e);
    osc_lost <= (c == 16'h0) && tick_on;
    stop_req <= 0;
    wake_req <= 1;
  endtask
  task woke(input int n);
    for (int i = 0; i < n && sys_clk_en !== 1'b1; i++) @(posedge ref_clk);
    chk(sys_clk_en, 1);
    wake_req <= 0;
    repeat (4) @(posedge ref_clk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(21));
    reset(1);
    v = $urandom & 32'hffec;
    bus(12'h000, 1, v, 0, 0);
    bus(12'h000, 0, 0, v, 32'hffffffff);
    for (m = 0; m < 2; m++) begin
      bus(12'h004, 0, 0, {strap_pll_mode, strap_pll_sel, strap_pll_ref, 5'h0},
        32'hffffffe1);
      bus(12'h004, 1, 32'hffffffff, 0, 0);
    end
    bus(12'h0fc, 0, 0, 0, 32'hffffffff);
    for (m = 0; m < 4; m++) begin
      stop(16'h20 | (m << 2), m == 0 ? 4'h7 : m == 1 ? 4'h6 : m == 2 ? 4'h2 : 4'h0);
      woke(30);
    end
    stop(16'h0, 4'h7);
    repeat (40) @(posedge ref_clk);
    chk(sys_clk_en, 0);
    tick_on <= 1;
    woke(1000);
    bus(12'h004, 0, 0, 32'h8, 32'h8);
    tick_on <= 0;
    repeat (400) @(posedge ref_clk);
    tick_on <= 1;
    stop(16'h0, 4'h7);
    tick_on <= 0;
    woke(60);
    chk(self_clocked | ref_clock_mode, 1);
    osc_lost <= 0;
    reset(0);
    bus(12'h004, 0, 0, {3'h0, 5'h0}, 32'h80);
    stop(16'h0, 4'h7);
    woke(30);
    conclude();
  end
endmodule
